// ==== logic/gpc_bank.sv ====
// Pin control bank for general purpose pins 1.6 to 2.7 with an AXI4-Lite slave.
// Assumes pad inputs synchronous to i_clock and alternate-function units outside.
// Every output is registered, so pins and views lag their inputs by one clock.
`timescale 1ns/1ps
`include "gpc_params.svh"

module gpc_bank (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [11:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [11:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic [`GPC_NPIN-1:0] i_pad_in,
   output gpc_pkg::gpc_pad_t o_pad,
   input wire logic [`GPC_NPIN-1:0] i_gpio_out,
   output logic [`GPC_NPIN-1:0] o_gpio_in,
   input wire logic i_floppy_drive_select_1_n,
   input wire logic i_floppy_motor_select_1_n,
   input wire logic i_music_serial_transmit,
   input wire logic i_sys_mgmt_interrupt_out_n,
   input wire gpc_pkg::gpc_kbc_t i_kbc_port_drive,
   output gpc_pkg::gpc_kbc_t o_kbc_port,
   output logic o_stick2_x_axis_timing,
   output logic o_stick2_y_axis_timing,
   output logic o_music_serial_receive,
   output logic o_irq
);
   import gpc_pkg::*;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------

   // Maps a word index to a pin slot; the reserved index has none.
   function automatic logic [3:0] slot_of(input logic [9:0] idx);
      case (idx)
         `GPC_IDX_PIN_1_6: slot_of = `GPC_S16;
         `GPC_IDX_PIN_1_7: slot_of = `GPC_S17;
         `GPC_IDX_PIN_2_0: slot_of = `GPC_S20;
         `GPC_IDX_PIN_2_1: slot_of = `GPC_S21;
         `GPC_IDX_PIN_2_2: slot_of = `GPC_S22;
         `GPC_IDX_PIN_2_4: slot_of = `GPC_S24;
         `GPC_IDX_PIN_2_5: slot_of = `GPC_S25;
         `GPC_IDX_PIN_2_6: slot_of = `GPC_S26;
         `GPC_IDX_PIN_2_7: slot_of = `GPC_S27;
         default: slot_of = `GPC_SNONE;
      endcase
   endfunction : slot_of

   // Writable bits of each slot; everything else stays zero.
   function automatic logic [7:0] wmask_of(input logic [3:0] s);
      case (s)
         `GPC_S21, `GPC_S22: wmask_of = `GPC_WMASK_TWO;
         `GPC_S24: wmask_of = `GPC_WMASK_NONE;
         default: wmask_of = `GPC_WMASK_ONE;
      endcase
   endfunction : wmask_of

   // Function select of a slot; single-select pins report KBC code when set.
   function automatic logic [1:0] sel_of(input logic [3:0] s, input logic [7:0] c);
      if (s == `GPC_S21 || s == `GPC_S22) begin
         sel_of = c[`GPC_B_SELHI:`GPC_B_ALT];
      end else begin
         sel_of = {1'b0, c[`GPC_B_ALT]};
      end
   endfunction : sel_of

   // ------------------------------------------------------------
   // Register storage and bus decode
   // ------------------------------------------------------------
   // Stored control bytes, event status, interrupt mask and bus channel state.
   logic [7:0] ctl [0:`GPC_NPIN-1];
   logic [1:0] status;
   logic [1:0] mask;
   gpc_wstate_t wstate;
   gpc_rstate_t rstate;
   logic aw_held;
   logic w_held;
   logic [9:0] aw_idx;
   logic [7:0] w_byte;
   logic w_lane0;
   logic [`GPC_NPIN-1:0] prev_in;

   // Write decode: the word is acted on once both halves are held.
   // The later half of a split write is used straight from the bus.
   wire aw_take = i_awvalid & o_awready;
   wire w_take = i_wvalid & o_wready;
   wire [9:0] wr_idx = aw_take ? i_awaddr[11:2] : aw_idx;
   wire [7:0] wr_byte = w_take ? i_wdata[7:0] : w_byte;
   wire wr_lane0 = w_take ? i_wstrb[0] : w_lane0;
   wire wr_go = (wstate == GPC_WS_IDLE) & (aw_held | aw_take) & (w_held | w_take);
   wire [3:0] wr_slot = slot_of(wr_idx);
   wire wr_pin = wr_slot != `GPC_SNONE;
   wire wr_ok = wr_pin | (wr_idx == `GPC_IDX_RSVD) | (wr_idx == `GPC_IDX_STATUS)
      | (wr_idx == `GPC_IDX_MASK);

   // Read decode; the reserved slot answers zero with OKAY.
   wire rd_take = i_arvalid & o_arready;
   wire [9:0] rd_idx = i_araddr[11:2];
   wire [3:0] rd_slot = slot_of(rd_idx);
   wire rd_pin = rd_slot != `GPC_SNONE;
   wire rd_stat = rd_idx == `GPC_IDX_STATUS;
   wire rd_mask = rd_idx == `GPC_IDX_MASK;
   wire rd_ok = rd_pin | rd_stat | rd_mask | (rd_idx == `GPC_IDX_RSVD);
   // The array index is kept in range; the pin flag already picks the value.
   wire [3:0] rd_ix = rd_pin ? rd_slot : `GPC_S16;
   wire [7:0] rd_byte = rd_pin ? ctl[rd_ix] : rd_stat ? {6'h00, status}
      : rd_mask ? {6'h00, mask} : 8'h00;

   // ------------------------------------------------------------
   // Pin steering
   // ------------------------------------------------------------
   // Per-pin views that the registers below take on every edge.
   logic [`GPC_NPIN-1:0] next_out;
   logic [`GPC_NPIN-1:0] next_oe;
   logic [`GPC_NPIN-1:0] in_logic;
   logic [`GPC_NPIN-1:0] alt_in;
   logic [`GPC_NPIN-1:0] kbc_sel;

   // Per pin: choose the source, invert it, then apply direction and driver type.
   // Input-only functions never drive, so a stale direction bit cannot fight the pin.
   always_comb begin
      logic [1:0] sel;
      logic [7:0] c;
      logic v;
      logic aout;
      logic ain;
      logic drive;
      sel = `GPC_SEL_GPIO;
      c = 8'h00;
      v = 1'b0;
      aout = 1'b0;
      ain = 1'b0;
      drive = 1'b0;
      // Slot order follows the pin numbering, so s is also the pad bit index.
      for (int s = 0; s < `GPC_NPIN; s++) begin
         c = ctl[s];
         sel = sel_of(4'(s), c);
         aout = 1'b0;
         ain = 1'b0;
         kbc_sel[s] = 1'b0;
         v = i_gpio_out[s];
         case (4'(s))
            `GPC_S16, `GPC_S17: ain = sel != `GPC_SEL_GPIO;
            `GPC_S20: kbc_sel[s] = sel == `GPC_SEL_KBC;
            `GPC_S21: begin
               aout = sel == `GPC_SEL_FDD;
               ain = sel == `GPC_SEL_EDGE;
               kbc_sel[s] = sel == `GPC_SEL_KBC;
               v = aout ? i_floppy_drive_select_1_n : v;
            end
            `GPC_S22: begin
               aout = sel == `GPC_SEL_FDD;
               ain = sel == `GPC_SEL_EDGE;
               kbc_sel[s] = sel == `GPC_SEL_KBC;
               v = aout ? i_floppy_motor_select_1_n : v;
            end
            `GPC_S25: ain = sel != `GPC_SEL_GPIO;
            `GPC_S26: begin
               aout = sel != `GPC_SEL_GPIO;
               v = aout ? i_music_serial_transmit : v;
            end
            `GPC_S27: begin
               aout = sel != `GPC_SEL_GPIO;
               v = aout ? i_sys_mgmt_interrupt_out_n : v;
            end
            default: aout = 1'b0;
         endcase
         // Port functions take their source here and follow the direction bit.
         if (kbc_sel[s]) begin
            v = (4'(s) == `GPC_S20) ? i_kbc_port_drive.bit7
               : (4'(s) == `GPC_S21) ? i_kbc_port_drive.bit6 : i_kbc_port_drive.bit2;
         end
         v = v ^ c[`GPC_B_POL];
         // Alternate outputs drive regardless of bit 0; input functions never drive.
         drive = aout | (~ain & ~c[`GPC_B_DIR]);
         next_out[s] = c[`GPC_B_OD] ? 1'b0 : v;
         next_oe[s] = drive & (c[`GPC_B_OD] ? ~v : 1'b1);
         in_logic[s] = i_pad_in[s] ^ c[`GPC_B_POL];
         alt_in[s] = ain;
      end
   end

   // Either-edge events on pins 2.1 and 2.2 while their edge function is chosen.
   wire [1:0] edge_ev = {alt_in[`GPC_S22] & ~kbc_sel[`GPC_S22]
      & (in_logic[`GPC_S22] ^ prev_in[`GPC_S22]),
      alt_in[`GPC_S21] & (in_logic[`GPC_S21] ^ prev_in[`GPC_S21])};
   wire stat_clr = rd_take & rd_stat;
   wire [1:0] next_status = (stat_clr ? 2'b00 : status) | edge_ev;

   // The mask as it stands after this edge, so a mask write moves the interrupt
   // at once instead of one clock after the register has changed.
   wire wr_mask = wr_go & wr_lane0 & (wr_idx == `GPC_IDX_MASK);
   wire [1:0] next_mask = wr_mask ? wr_byte[1:0] : mask;

   // ------------------------------------------------------------
   // Control registers, status and interrupt
   // ------------------------------------------------------------

   // Writes keep only the documented bits; a write without lane 0 changes nothing.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         for (int s = 0; s < `GPC_NPIN; s++) begin
            ctl[s] <= `GPC_CTL_RST;
         end
         mask <= 2'b00;
      end else if (wr_go & wr_lane0) begin
         // The mask shares this write path; the status word ignores writes.
         if (wr_pin) begin
            ctl[wr_slot] <= wr_byte & wmask_of(wr_slot);
         end
         if (wr_idx == `GPC_IDX_MASK) begin
            mask <= wr_byte[1:0];
         end
      end
   end

   // A new edge in the clearing read's cycle survives the clear.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         status <= 2'b00;
         // A low start matches the idle level of an uninverted pad: no false edge.
         prev_in <= '0;
         o_irq <= 1'b0;
      end else begin
         status <= next_status;
         prev_in <= in_logic;
         o_irq <= |(next_status & next_mask);
      end
   end

   // Registered pad drive and logic-side views of the pins.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_pad <= '0;
         o_gpio_in <= '0;
         // Port bits idle high, as a released open-drain line reads.
         o_kbc_port <= 3'b111;
         o_stick2_x_axis_timing <= 1'b0;
         o_stick2_y_axis_timing <= 1'b0;
         o_music_serial_receive <= 1'b0;
      end else begin
         o_pad.out <= next_out;
         o_pad.oe <= next_oe;
         o_gpio_in <= in_logic;
         o_kbc_port.bit7 <= kbc_sel[`GPC_S20] ? in_logic[`GPC_S20] : 1'b1;
         o_kbc_port.bit6 <= kbc_sel[`GPC_S21] ? in_logic[`GPC_S21] : 1'b1;
         o_kbc_port.bit2 <= kbc_sel[`GPC_S22] ? in_logic[`GPC_S22] : 1'b1;
         o_stick2_x_axis_timing <= alt_in[`GPC_S16] & in_logic[`GPC_S16];
         o_stick2_y_axis_timing <= alt_in[`GPC_S17] & in_logic[`GPC_S17];
         o_music_serial_receive <= alt_in[`GPC_S25] & in_logic[`GPC_S25];
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------

   // Address and data are taken in either order; one write is open at a time.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         wstate <= GPC_WS_IDLE;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= `GPC_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= '0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else begin
         case (wstate)
            GPC_WS_IDLE: begin
               if (aw_take) begin
                  aw_held <= 1'b1;
                  aw_idx <= i_awaddr[11:2];
                  o_awready <= 1'b0;
               end
               if (w_take) begin
                  w_held <= 1'b1;
                  w_byte <= i_wdata[7:0];
                  w_lane0 <= i_wstrb[0];
                  o_wready <= 1'b0;
               end
               if (wr_go) begin
                  o_bvalid <= 1'b1;
                  o_bresp <= wr_ok ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
                  wstate <= GPC_WS_RESP;
               end
            end
            GPC_WS_RESP: begin
               // Both ready flags return together once the response is taken.
               if (i_bready) begin
                  o_bvalid <= 1'b0;
                  aw_held <= 1'b0;
                  w_held <= 1'b0;
                  o_awready <= 1'b1;
                  o_wready <= 1'b1;
                  wstate <= GPC_WS_IDLE;
               end
            end
            default: wstate <= GPC_WS_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------

   // Data are captured at the address edge, so the status clear and the
   // returned value always refer to the same cycle.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         rstate <= GPC_RS_IDLE;
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= `GPC_RESP_OKAY;
      end else begin
         case (rstate)
            GPC_RS_IDLE: begin
               if (rd_take) begin
                  o_arready <= 1'b0;
                  o_rvalid <= 1'b1;
                  o_rdata <= {24'h00_0000, rd_byte};
                  o_rresp <= rd_ok ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
                  rstate <= GPC_RS_RESP;
               end
            end
            GPC_RS_RESP: begin
               // Only one read is open; arready stays low until the data are taken.
               if (i_rready) begin
                  o_rvalid <= 1'b0;
                  o_arready <= 1'b1;
                  rstate <= GPC_RS_IDLE;
               end
            end
            default: rstate <= GPC_RS_IDLE;
         endcase
      end
   end

endmodule : gpc_bank

// ==== logic/gpc_params.svh ====
// Constants for the general purpose pin control bank.
// Assumes inclusion by the bank package, the bank module, the monitor and the testbench.
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH
// Register indices; the byte address on the bus is four times the index.
`define GPC_IDX_PIN_1_6 10'h029
`define GPC_IDX_PIN_1_7 10'h02a
`define GPC_IDX_PIN_2_0 10'h02b
`define GPC_IDX_PIN_2_1 10'h02c
`define GPC_IDX_PIN_2_2 10'h02d
`define GPC_IDX_RSVD 10'h02e
`define GPC_IDX_PIN_2_4 10'h02f
`define GPC_IDX_PIN_2_5 10'h030
`define GPC_IDX_PIN_2_6 10'h031
`define GPC_IDX_PIN_2_7 10'h032
`define GPC_IDX_STATUS 10'h080
`define GPC_IDX_MASK 10'h081
// Pin slots inside the bank.
`define GPC_NPIN 9
`define GPC_S16 4'd0
`define GPC_S17 4'd1
`define GPC_S20 4'd2
`define GPC_S21 4'd3
`define GPC_S22 4'd4
`define GPC_S24 4'd5
`define GPC_S25 4'd6
`define GPC_S26 4'd7
`define GPC_S27 4'd8
`define GPC_SNONE 4'hf
// Control fields, reset value and writable masks.
`define GPC_B_DIR 0
`define GPC_B_POL 1
`define GPC_B_ALT 2
`define GPC_B_SELHI 3
`define GPC_B_OD 7
`define GPC_CTL_RST 8'h01
`define GPC_WMASK_ONE 8'h87
`define GPC_WMASK_TWO 8'h8f
`define GPC_WMASK_NONE 8'h83
// Two-bit select codes.
`define GPC_SEL_GPIO 2'h0
`define GPC_SEL_KBC 2'h1
`define GPC_SEL_EDGE 2'h2
`define GPC_SEL_FDD 2'h3
// Interrupt status bits and bus answers.
`define GPC_EV_EDGE0 0
`define GPC_EV_EDGE1 1
`define GPC_RESP_OKAY 2'h0
`define GPC_RESP_SLVERR 2'h2
`endif

// ==== logic/gpc_pkg.sv ====
// Types shared by the general purpose pin control bank.
// Assumes the constants header sits beside it.
`include "gpc_params.svh"
package gpc_pkg;
   // Pad drive of the nine pins, slot order 1.6 up to 2.7.
   typedef struct packed {
      logic [`GPC_NPIN-1:0] out;
      logic [`GPC_NPIN-1:0] oe;
   } gpc_pad_t;
   // Keyboard controller port bits carried through the bank.
   typedef struct packed {
      logic bit7;
      logic bit6;
      logic bit2;
   } gpc_kbc_t;
   typedef enum logic [1:0] {GPC_WS_IDLE = 2'b01, GPC_WS_RESP = 2'b10} gpc_wstate_t;
   typedef enum logic [1:0] {GPC_RS_IDLE = 2'b01, GPC_RS_RESP = 2'b10} gpc_rstate_t;
endpackage : gpc_pkg

// ==== bench/gpc_monitor.sv ====
// Checker for the pin control bank: pin 1.6 drive and sense, read data shape.
// Assumes writes offer address and data together; a split write is not shadowed.
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_monitor (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [11:0] i_awaddr,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [11:0] i_araddr,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic [`GPC_NPIN-1:0] i_pad_in,
   input wire gpc_pkg::gpc_pad_t o_pad,
   input wire logic [`GPC_NPIN-1:0] i_gpio_out,
   input wire logic [`GPC_NPIN-1:0] o_gpio_in,
   input wire logic o_stick2_x_axis_timing
);
   import gpc_pkg::*;
   logic [7:0] ctl16;
   // Take decodes; a write counts only when both halves go at one edge.
   wire logic wr16 = i_awvalid && o_awready && i_wvalid && o_wready && i_wstrb[0]
      && (i_awaddr[11:2] == `GPC_IDX_PIN_1_6);
   wire logic ar_take = i_arvalid && o_arready;
   // Shadow of the pin 1.6 control byte, updated on the same edge as the bank.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ctl16 <= `GPC_CTL_RST;
      end else if (wr16) begin
         ctl16 <= i_wdata[7:0] & `GPC_WMASK_ONE;
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   chk_dir_input: assert property (ctl16[0] && !ctl16[2] |=> !o_pad.oe[0])
      else $error("Pin 1.6 driven while set as input.");
   chk_push_pull: assert property (!ctl16[0] && !ctl16[2] && !ctl16[7] |=>
      o_pad.oe[0] && (o_pad.out[0] == ($past(i_gpio_out[0]) ^ $past(ctl16[1]))))
      else $error("Pin 1.6 push-pull value wrong.");
   chk_open_drain: assert property (!ctl16[0] && !ctl16[2] && ctl16[7] |=>
      !o_pad.out[0] && (o_pad.oe[0] == !($past(i_gpio_out[0]) ^ $past(ctl16[1]))))
      else $error("Pin 1.6 open-drain drive wrong.");
   chk_stick_route: assert property (i_nrst ##1 1'b1 |-> o_stick2_x_axis_timing ==
      ($past(ctl16[2]) && ($past(i_pad_in[0]) ^ $past(ctl16[1]))))
      else $error("Stick X timing not routed as selected.");
   chk_pin_sense: assert property (i_nrst |=>
      o_gpio_in[0] == ($past(i_pad_in[0]) ^ $past(ctl16[1])))
      else $error("Pin 1.6 sensed level wrong.");
   chk_rsvd_slot: assert property (ar_take && i_araddr[11:2] == `GPC_IDX_RSVD |=>
      o_rvalid && o_rdata == 32'h0)
      else $error("Empty slot read nonzero.");
   chk_rsvd_bits: assert property (ar_take |=>
      o_rdata[31:8] == 24'h0 && o_rdata[6:4] == 3'h0)
      else $error("Reserved read bits nonzero.");
   chk_alt_absent: assert property (ar_take && i_araddr[11:2] == `GPC_IDX_PIN_2_4 |=>
      o_rdata[6:2] == 5'h0)
      else $error("Pin 2.4 select bit reads set.");
endmodule : gpc_monitor

// ==== bench/testbench.sv ====
// Self-checking bench for the pin control bank over AXI4-Lite.
// Assumes the bank answers a request within a few cycles; all waits are bounded.
`timescale 1ns/1ps
`include "gpc_params.svh"
module testbench;
   import gpc_pkg::*;
   logic i_clock = 1'b0, i_nrst = 1'b0;
   logic [11:0] i_awaddr = 12'h0, i_araddr = 12'h0;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0, i_bready = 1'b1, i_rready = 1'b1;
   logic [31:0] i_wdata = 32'h0;
   logic [3:0] i_wstrb = 4'h0;
   logic [8:0] i_pad_in = 9'h0, i_gpio_out = 9'h0;
   logic i_floppy_drive_select_1_n = 1'b1, i_floppy_motor_select_1_n = 1'b1;
   logic i_music_serial_transmit = 1'b0, i_sys_mgmt_interrupt_out_n = 1'b1;
   gpc_kbc_t i_kbc_port_drive = 3'h7;
   wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   wire logic [1:0] o_bresp, o_rresp;
   wire logic [31:0] o_rdata;
   wire gpc_pad_t o_pad;
   wire logic [8:0] o_gpio_in;
   wire gpc_kbc_t o_kbc_port;
   wire logic o_stick2_x_axis_timing, o_stick2_y_axis_timing, o_music_serial_receive;
   int bad_count = 0, n_tests = 0, s;
   logic [8:0] e9;
   logic [15:0] seed = 16'h0037;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [9:0] idx_t[10] = '{`GPC_IDX_PIN_1_6, `GPC_IDX_PIN_1_7, `GPC_IDX_PIN_2_0,
      `GPC_IDX_PIN_2_1, `GPC_IDX_PIN_2_2, `GPC_IDX_RSVD, `GPC_IDX_PIN_2_4,
      `GPC_IDX_PIN_2_5, `GPC_IDX_PIN_2_6, `GPC_IDX_PIN_2_7};
   logic [7:0] wm_t[10] = '{8'h87, 8'h87, 8'h87, 8'h8f, 8'h8f, 8'h00, 8'h83, 8'h87, 8'h87, 8'h87};
   logic [7:0] ctl_t[8] = '{8'h00, 8'h02, 8'h82, 8'h80, 8'h05, 8'h0c, 8'h0b, 8'h86};
   gpc_bank dut (.i_clock, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
      .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
      .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pad_in, .o_pad, .i_gpio_out, .o_gpio_in,
      .i_floppy_drive_select_1_n, .i_floppy_motor_select_1_n, .i_music_serial_transmit,
      .i_sys_mgmt_interrupt_out_n, .i_kbc_port_drive, .o_kbc_port, .o_stick2_x_axis_timing,
      .o_stick2_y_axis_timing, .o_music_serial_receive, .o_irq);
   // ----------
   // Helpers
   // ----------
   always #2.5 i_clock = ~i_clock;
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   // Expected pin view for slot p with control byte c, from the bench's own stimulus.
   function automatic logic [8:0] model(input int p, input logic [7:0] c);
      logic vin, src, aout, ain, kbs, v, drv;
      logic [2:0] alt;
      logic two;
      two = (p == 3 || p == 4);
      vin = i_pad_in[p] ^ c[1];
      ain = (p < 2 || p == 6) ? c[2] : two && c[3:2] == 2'h2;
      aout = (p > 6) ? c[2] : two && c[3:2] == 2'h3;
      kbs = (p == 2) ? c[2] : two && c[3:2] == 2'h1;
      alt = {p == 0 && c[2], p == 1 && c[2], p == 6 && c[2]} & {3{vin}};
      src = aout ? (p == 3 ? i_floppy_drive_select_1_n : p == 4 ? i_floppy_motor_select_1_n
         : p == 7 ? i_music_serial_transmit : i_sys_mgmt_interrupt_out_n)
         : kbs ? i_kbc_port_drive[4 - p] : i_gpio_out[p];
      v = src ^ c[1];
      drv = aout | (!ain & !c[0]);
      return {c[7] ? drv & !v : drv, !c[7] & v, vin, alt,
         ~({p == 2, p == 3, p == 4} & {3{kbs}}) | {3{vin}}};
   endfunction : model
   function automatic logic [8:0] seen(input int p);
      return {o_pad.oe[p], o_pad.out[p], o_gpio_in[p], o_stick2_x_axis_timing,
         o_stick2_y_axis_timing, o_music_serial_receive, o_kbc_port};
   endfunction : seen
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for a handshake: 0 aw and w, 1 b, 2 ar, 3 r.
   task automatic await(input int w);
      int n;
      logic hit;
      n = 0;
      hit = 1'b0;
      while (!hit && n < 50) begin
         @(posedge i_clock);
         n++;
         hit = ((w == 0) ? o_awready && o_wready : (w == 1) ? o_bvalid
            : (w == 2) ? o_arready : o_rvalid) === 1'b1;
      end
      if (!hit) begin
         bad_count++;
         $display("[ERR] t=%0t handshake %0d seen=%h exp=%h", $time, w, 1'b0, 1'b1);
         conclude();
      end
   endtask : await
   task automatic wr(input logic [9:0] ix, input logic [7:0] d, input logic [3:0] st,
      input logic [1:0] rs);
      bq.push_back(rs);
      i_awaddr <= {ix, 2'b00};
      i_wdata <= {24'h0, d};
      i_wstrb <= st;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      await(0);
      i_awvalid <= 1'b0;
      i_wvalid <= 1'b0;
      await(1);
   endtask : wr
   task automatic rd(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] rs);
      rq.push_back({rs, 24'h0, d});
      i_araddr <= {ix, 2'b00};
      i_arvalid <= 1'b1;
      await(2);
      i_arvalid <= 1'b0;
      await(3);
   endtask : rd
   // Answers are matched in order against the notes left by the tasks.
   always @(posedge i_clock) begin
      if (i_nrst === 1'b1 && o_rvalid === 1'b1) begin
         chk({o_rresp, o_rdata}, rq.size() > 0 ? rq.pop_front() : 'x);
      end
      if (i_nrst === 1'b1 && o_bvalid === 1'b1) begin
         chk(34'(o_bresp), bq.size() > 0 ? 34'(bq.pop_front()) : 'x);
      end
   end
   // ----------
   // Scenarios
   // ----------
   initial begin
      repeat (10) @(posedge i_clock);
      i_nrst <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         rd(idx_t[i], (i == 5) ? 8'h00 : `GPC_CTL_RST, `GPC_RESP_OKAY);
      end
      // Edge events on pins 2.1 and 2.2, masked and unmasked, cleared by reading.
      wr(`GPC_IDX_MASK, 8'h03, 4'h1, `GPC_RESP_OKAY);
      wr(`GPC_IDX_PIN_2_1, 8'h09, 4'h1, `GPC_RESP_OKAY);
      wr(`GPC_IDX_PIN_2_2, 8'h09, 4'h1, `GPC_RESP_OKAY);
      i_pad_in <= 9'h018;
      repeat (3) @(posedge i_clock);
      chk(34'(o_irq), 34'h1);
      rd(`GPC_IDX_STATUS, 8'h03, `GPC_RESP_OKAY);
      repeat (2) @(posedge i_clock);
      chk(34'(o_irq), 34'h0);
      wr(`GPC_IDX_MASK, 8'h00, 4'h1, `GPC_RESP_OKAY);
      i_pad_in <= 9'h010;
      repeat (3) @(posedge i_clock);
      chk(34'(o_irq), 34'h0);
      wr(`GPC_IDX_MASK, 8'h01, 4'h1, `GPC_RESP_OKAY);
      repeat (2) @(posedge i_clock);
      chk(34'(o_irq), 34'h1);
      rd(`GPC_IDX_STATUS, 8'h01, `GPC_RESP_OKAY);
      // Strobe off, random round trips, then an unmapped word.
      wr(`GPC_IDX_PIN_1_6, 8'hff, 4'h0, `GPC_RESP_OKAY);
      rd(`GPC_IDX_PIN_1_6, `GPC_CTL_RST, `GPC_RESP_OKAY);
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         wr(idx_t[i], seed[7:0], 4'h1, `GPC_RESP_OKAY);
         rd(idx_t[i], seed[7:0] & wm_t[i], `GPC_RESP_OKAY);
         wr(idx_t[i], `GPC_CTL_RST, 4'h1, `GPC_RESP_OKAY);
      end
      wr(10'h100, 8'h5a, 4'h1, `GPC_RESP_SLVERR);
      rd(10'h100, 8'h00, `GPC_RESP_SLVERR);
      // Every pin through a table of modes with random pad and source levels.
      for (int i = 0; i < 10; i++) begin
         for (int k = 0; k < 8 && i != 5; k++) begin
            wr(idx_t[i], ctl_t[k], 4'h1, `GPC_RESP_OKAY);
            seed = lfsr(seed);
            i_gpio_out <= seed[8:0];
            {i_floppy_drive_select_1_n, i_floppy_motor_select_1_n, i_music_serial_transmit,
               i_sys_mgmt_interrupt_out_n, i_kbc_port_drive} <= seed[15:9];
            seed = lfsr(seed);
            i_pad_in <= seed[8:0];
            repeat (2) @(posedge i_clock);
            s = (i < 5) ? i : i - 1;
            e9 = model(s, ctl_t[k] & wm_t[i]);
            chk(34'(seen(s)), 34'(e9));
         end
         wr(idx_t[i], `GPC_CTL_RST, 4'h1, `GPC_RESP_OKAY);
      end
      repeat (2) @(posedge i_clock);
      conclude();
   end
endmodule : testbench
bind gpc_bank gpc_monitor mon (.i_clock, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
   .i_wstrb, .i_wvalid, .o_wready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
   .i_pad_in, .o_pad, .i_gpio_out, .o_gpio_in, .o_stick2_x_axis_timing);
